// ### rtl/dtc_defs.vh
// Offsets, field positions, reset values and timing counts of the dual timer/counter unit
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// Register offsets on the local register port
`define DTC_ADDR_W 3
`define DTC_OFF_MODE 3'h0
`define DTC_OFF_CTRL 3'h1
`define DTC_OFF_U0_LO 3'h2
`define DTC_OFF_U0_HI 3'h3
`define DTC_OFF_U1_LO 3'h4
`define DTC_OFF_U1_HI 3'h5
// Mode register: per-unit nibble, unit 1 sits four bits above unit 0
`define DTC_MODE_SEL_LO 0
`define DTC_MODE_SEL_HI 1
`define DTC_MODE_CT 2
`define DTC_MODE_GATE 3
`define DTC_MODE_U1_SHIFT 4
// Control register fields
`define DTC_CTRL_IRQ0_TYPE 0
`define DTC_CTRL_IRQ0_EDGE 1
`define DTC_CTRL_IRQ1_TYPE 2
`define DTC_CTRL_IRQ1_EDGE 3
`define DTC_CTRL_U0_RUN 4
`define DTC_CTRL_U0_OVF 5
`define DTC_CTRL_U1_RUN 6
`define DTC_CTRL_U1_OVF 7
// Mode encodings
`define DTC_M_13BIT 2'h0
`define DTC_M_16BIT 2'h1
`define DTC_M_RELOAD 2'h2
`define DTC_M_SPLIT 2'h3
// Reset values
`define DTC_RST_BYTE 8'h00
// Oscillator periods per machine cycle, and last divider state
`define DTC_MC_DIV 12
`define DTC_MC_LAST 4'hb
// Pin order inside the input conditioning vector
`define DTC_PIN_CNT0 0
`define DTC_PIN_CNT1 1
`define DTC_PIN_IRQ0 2
`define DTC_PIN_IRQ1 3
`endif

// ### rtl/dtc_timer_unit.v
// Dual 16-bit timer/counter unit with mode and control registers
//
// Behaviour
// R01: Timer operation increments the count once per machine cycle, twelve oscillator clocks.
// R02: Counter operation increments on a falling edge seen at the unit count pin.
// R03: A pin falling edge takes two machine cycles to recognise.
// R04: Outside source holds each pin level at least one machine cycle.
// R05: Mode 0 is 13-bit: low five bits prescale by 32 into the high byte.
// R06: Mode 0 leaves the upper three low-byte bits out of counting.
// R07: Setting run starts from present byte contents without clearing them.
// R08: Wrap of the active chain from all ones to zero sets the overflow flag.
// R09: Mode 1 counts all sixteen bits.
// R10: Mode 2 counts the low byte, reloading it from the high byte on overflow.
// R11: Split: unit 0 low byte as usual; high byte times under unit 1 run.
// R12: Unit 1 in mode 3 stops and holds its count.
// R13: Mode register low nibble is unit 0, high nibble unit 1: gate, select, mode.
// R14: Mode bits pick 13-bit, 16-bit, 8-bit reload, split or stopped.
// R15: Select bit one counts pin edges, zero counts machine cycles.
// R16: With gate set, counting needs interrupt pin high and run set.
// R17: Control register holds overflow, run, edge flag and type for each unit and pin.
// R18: Interrupt type bit chooses falling edge or low level as the request.
// R19: Edge flag set on pin falling edge, cleared when the interrupt is serviced.
// R20: Clearing run stops a unit; split mode unit 1 run drives unit 0 high byte.
// R21: Overflow flags are set by hardware only and cleared by software. The code also sets them when software writes a one to the control register.
// R22: Reset clears mode, control and all four count bytes.
// R23: Pins are sampled once per machine cycle; high then low sample is a falling edge.
// R24: Split mode: unit 0 high byte sets unit 1 overflow flag, unit 1 cannot.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.vh"

module dtc_timer_unit (
  input wire core_clk_i, // Oscillator clock, 10 MHz
  input wire rst_n_i, // Chip reset, active low, asynchronous
  input wire [`DTC_ADDR_W-1:0] reg_addr_i, // Register offset
  input wire [7:0] reg_wdata_i, // Write data
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  output reg [7:0] reg_rdata_o, // Read data, cycle after the strobe
  input wire unit0_count_pin_i, // Unit 0 external count pin
  input wire unit1_count_pin_i, // Unit 1 external count pin
  input wire ext_irq0_pin_i, // External interrupt 0 pin, also unit 0 gate
  input wire ext_irq1_pin_i, // External interrupt 1 pin, also unit 1 gate
  input wire ext_irq0_ack_i, // Interrupt 0 serviced, one-cycle pulse
  input wire ext_irq1_ack_i, // Interrupt 1 serviced, one-cycle pulse
  output reg ext_irq0_req_o, // Interrupt 0 request level
  output reg ext_irq1_req_o, // Interrupt 1 request level
  output reg unit0_overflow_flag_o, // Unit 0 overflow flag copy
  output reg unit1_overflow_flag_o // Unit 1 overflow flag copy
);

  // Reset release synchroniser
  // Assert at once, lift two clocks later so no flop sees a ragged release
  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // Machine cycle divider: one enable pulse every twelve clocks
  // Starts at zero, so the first enable lands twelve clocks after reset
  reg [3:0] mc_cnt_r;
  wire mc_en;

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mc_cnt_r <= 4'h0;
    end else if (mc_cnt_r == `DTC_MC_LAST) begin
      mc_cnt_r <= 4'h0;
    end else begin
      mc_cnt_r <= mc_cnt_r + 4'h1;
    end
  end
  assign mc_en = (mc_cnt_r == `DTC_MC_LAST); // R01

  // Pin conditioning: two-flop sync, then one sample per machine cycle
  // Two flops first, since the pins are not on this clock
  wire [3:0] pin_in;
  wire [3:0] pin_fall;
  reg [3:0] pin_meta_r;
  reg [3:0] pin_sync_r;
  reg [3:0] pin_samp_r;

  assign pin_in = {ext_irq1_pin_i, ext_irq0_pin_i, unit1_count_pin_i, unit0_count_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      // Idle level high so reset release cannot fake an edge
      always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_r[gi] <= 1'b1;
          pin_sync_r[gi] <= 1'b1;
          pin_samp_r[gi] <= 1'b1;
        end else begin
          pin_meta_r[gi] <= pin_in[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
          if (mc_en) begin
            pin_samp_r[gi] <= pin_sync_r[gi]; // R23
          end
        end
      end
      // High sample last machine cycle, low sample now
      assign pin_fall[gi] = mc_en & pin_samp_r[gi] & ~pin_sync_r[gi]; // R03 R23
    end
  endgenerate

  // Software-visible registers
  reg [7:0] mode_r;
  reg [7:0] ctrl_r;
  reg [7:0] u0_lo_r;
  reg [7:0] u0_hi_r;
  reg [7:0] u1_lo_r;
  reg [7:0] u1_hi_r;

  // Per-unit fields of the mode register
  wire [1:0] u0_mode;
  wire [1:0] u1_mode;
  wire u0_ct;
  wire u1_ct;
  wire u0_gate;
  wire u1_gate;

  assign u0_mode = {mode_r[`DTC_MODE_SEL_HI], mode_r[`DTC_MODE_SEL_LO]}; // R13 R14
  assign u1_mode = {mode_r[`DTC_MODE_SEL_HI + `DTC_MODE_U1_SHIFT],
                    mode_r[`DTC_MODE_SEL_LO + `DTC_MODE_U1_SHIFT]}; // R13 R14
  assign u0_ct = mode_r[`DTC_MODE_CT];
  assign u1_ct = mode_r[`DTC_MODE_CT + `DTC_MODE_U1_SHIFT];
  assign u0_gate = mode_r[`DTC_MODE_GATE];
  assign u1_gate = mode_r[`DTC_MODE_GATE + `DTC_MODE_U1_SHIFT];

  // Count enables: run, optional gate pin, then cycle or pin edge
  // Gate reads the per-cycle sample so it cannot flip inside one step
  wire u0_run;
  wire u1_run;
  wire u0_inc;
  wire u1_inc;
  wire u0_hi_inc;
  wire split;

  assign u0_run = ctrl_r[`DTC_CTRL_U0_RUN];
  assign u1_run = ctrl_r[`DTC_CTRL_U1_RUN];
  assign split = (u0_mode == `DTC_M_SPLIT);
  assign u0_inc = u0_run // R07 R20
                  & (~u0_gate | pin_samp_r[`DTC_PIN_IRQ0]) // R16
                  & (u0_ct ? pin_fall[`DTC_PIN_CNT0] : mc_en); // R01 R02 R15
  assign u1_inc = u1_run // R20
                  & (~u1_gate | pin_samp_r[`DTC_PIN_IRQ1]) // R16
                  & (u1_ct ? pin_fall[`DTC_PIN_CNT1] : mc_en) // R01 R02 R15
                  & (u1_mode != `DTC_M_SPLIT); // R12
  // Split high byte is a timer only, started by unit 1 run
  assign u0_hi_inc = split & u1_run & mc_en; // R11 R20

  // One count step; returns {overflow, high, low}
  // Unit 1 in mode 3 never steps; its enable is held low instead
  function [16:0] cnt_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [5:0] pre;
    reg [8:0] hsum;
    reg [8:0] lsum;
    reg [16:0] wsum;
    begin
      pre = {1'b0, lo[4:0]} + 6'h01;
      hsum = {1'b0, hi} + {8'h00, pre[5]};
      lsum = {1'b0, lo} + 9'h001;
      wsum = {1'b0, hi, lo} + 17'h0_0001;
      case (mode)
        // Upper three low bits held, they take no part
        `DTC_M_13BIT: cnt_step = {hsum[8], hsum[7:0], lo[7:5], pre[4:0]}; // R05 R06 R08
        `DTC_M_16BIT: cnt_step = wsum; // R09 R08
        `DTC_M_RELOAD: cnt_step = {lsum[8], hi, lsum[8] ? hi : lsum[7:0]}; // R10
        default: cnt_step = {lsum[8], hi, lsum[7:0]}; // R11
      endcase
    end
  endfunction

  wire [16:0] u0_step;
  wire [16:0] u1_step;
  wire [8:0] u0_hi_sum;

  assign u0_step = cnt_step(u0_mode, u0_lo_r, u0_hi_r);
  assign u1_step = cnt_step(u1_mode, u1_lo_r, u1_hi_r);
  assign u0_hi_sum = {1'b0, u0_hi_r} + 9'h001;

  // Overflow events of each chain
  wire u0_ovf_ev;
  wire u1_ovf_ev;
  wire u0_hi_ovf_ev;

  assign u0_ovf_ev = u0_inc & u0_step[16]; // R08
  assign u0_hi_ovf_ev = u0_hi_inc & u0_hi_sum[8]; // R24
  assign u1_ovf_ev = u1_inc & u1_step[16] & ~split; // R24

  // Write decode
  // Offsets six and seven decode to nothing, so writes there are dropped
  wire wr_mode;
  wire wr_ctrl;

  assign wr_mode = reg_wr_i & (reg_addr_i == `DTC_OFF_MODE);
  assign wr_ctrl = reg_wr_i & (reg_addr_i == `DTC_OFF_CTRL);

  // Count bytes: a software write wins over a same-cycle step
  // Bytes are read one at a time; a running 16-bit value may tear
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      u0_lo_r <= `DTC_RST_BYTE; // R22
      u0_hi_r <= `DTC_RST_BYTE; // R22
      u1_lo_r <= `DTC_RST_BYTE; // R22
      u1_hi_r <= `DTC_RST_BYTE; // R22
    end else begin
      if (reg_wr_i && reg_addr_i == `DTC_OFF_U0_LO) begin
        u0_lo_r <= reg_wdata_i;
      end else if (u0_inc) begin
        u0_lo_r <= u0_step[7:0];
      end
      if (reg_wr_i && reg_addr_i == `DTC_OFF_U0_HI) begin
        u0_hi_r <= reg_wdata_i;
      end else if (u0_hi_inc) begin
        u0_hi_r <= u0_hi_sum[7:0]; // R11
      end else if (u0_inc && !split) begin
        u0_hi_r <= u0_step[15:8];
      end
      if (reg_wr_i && reg_addr_i == `DTC_OFF_U1_LO) begin
        u1_lo_r <= reg_wdata_i;
      end else if (u1_inc) begin
        u1_lo_r <= u1_step[7:0];
      end
      if (reg_wr_i && reg_addr_i == `DTC_OFF_U1_HI) begin
        u1_hi_r <= reg_wdata_i;
      end else if (u1_inc) begin
        u1_hi_r <= u1_step[15:8];
      end
    end
  end

  // Mode register
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `DTC_RST_BYTE; // R22
    end else if (wr_mode) begin
      mode_r <= reg_wdata_i; // R13
    end
  end

  // Edge flags; level type never latches, the request follows the pin
  wire irq0_edge_ev;
  wire irq1_edge_ev;
  wire [7:0] ctrl_base;
  reg [7:0] ctrl_nxt;

  assign irq0_edge_ev = ctrl_r[`DTC_CTRL_IRQ0_TYPE] & pin_fall[`DTC_PIN_IRQ0]; // R18 R19
  assign irq1_edge_ev = ctrl_r[`DTC_CTRL_IRQ1_TYPE] & pin_fall[`DTC_PIN_IRQ1]; // R18 R19
  assign ctrl_base = wr_ctrl ? reg_wdata_i : ctrl_r;

  // Control register: hardware sets win over software or service clears
  always @* begin
    ctrl_nxt = ctrl_base; // R17
    if (ext_irq0_ack_i) begin
      ctrl_nxt[`DTC_CTRL_IRQ0_EDGE] = 1'b0; // R19
    end
    if (ext_irq1_ack_i) begin
      ctrl_nxt[`DTC_CTRL_IRQ1_EDGE] = 1'b0; // R19
    end
    if (irq0_edge_ev) begin
      ctrl_nxt[`DTC_CTRL_IRQ0_EDGE] = 1'b1; // R19
    end
    if (irq1_edge_ev) begin
      ctrl_nxt[`DTC_CTRL_IRQ1_EDGE] = 1'b1; // R19
    end
    // Hardware sets flags here, a software write of one sets them too; clearing is left to software
    if (u0_ovf_ev) begin
      ctrl_nxt[`DTC_CTRL_U0_OVF] = 1'b1; // R08 R21
    end
    if (u1_ovf_ev || u0_hi_ovf_ev) begin
      ctrl_nxt[`DTC_CTRL_U1_OVF] = 1'b1; // R21 R24
    end
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DTC_RST_BYTE; // R22
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Flag and request outputs, registered from next-state values
  // Next values used so the flag pins never lag the control bits
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      unit0_overflow_flag_o <= 1'b0;
      unit1_overflow_flag_o <= 1'b0;
      ext_irq0_req_o <= 1'b0;
      ext_irq1_req_o <= 1'b0;
    end else begin
      unit0_overflow_flag_o <= ctrl_nxt[`DTC_CTRL_U0_OVF];
      unit1_overflow_flag_o <= ctrl_nxt[`DTC_CTRL_U1_OVF];
      ext_irq0_req_o <= ctrl_nxt[`DTC_CTRL_IRQ0_TYPE] ?
                        ctrl_nxt[`DTC_CTRL_IRQ0_EDGE] : ~pin_samp_r[`DTC_PIN_IRQ0]; // R18
      ext_irq1_req_o <= ctrl_nxt[`DTC_CTRL_IRQ1_TYPE] ?
                        ctrl_nxt[`DTC_CTRL_IRQ1_EDGE] : ~pin_samp_r[`DTC_PIN_IRQ1]; // R18
    end
  end

  // Read mux; unmapped offsets read zero
  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr_i)
      `DTC_OFF_MODE: rd_mux = mode_r;
      `DTC_OFF_CTRL: rd_mux = ctrl_r;
      `DTC_OFF_U0_LO: rd_mux = u0_lo_r;
      `DTC_OFF_U0_HI: rd_mux = u0_hi_r;
      `DTC_OFF_U1_LO: rd_mux = u1_lo_r;
      `DTC_OFF_U1_HI: rd_mux = u1_hi_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  // Zero between reads keeps a stale byte off the bus
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### sim/dtc_pin_model.sv
// Outside source for the count and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic core_clk_i, // Clock
  output logic [3:0] pins_o // Count 0, count 1, irq 0, irq 1
);
  // Pins idle high through their pull-ups
  initial pins_o = 4'hf;
  // Falling edges; each level held a full machine cycle
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge core_clk_i) pins_o[idx] <= 1'b0;
      repeat (12) @(posedge core_clk_i);
      pins_o[idx] <= 1'b1;
      repeat (12) @(posedge core_clk_i);
    end
  endtask
  // Static level for gating and level requests
  task automatic hold(input int idx, input logic lvl);
    @(posedge core_clk_i) pins_o[idx] <= lvl;
  endtask
endmodule
`default_nettype wire

// ### sim/dtc_timer_props.sv
// Port assertions for the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.vh"
module dtc_timer_props (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [`DTC_ADDR_W-1:0] reg_addr_i, // Offset
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire logic ext_irq0_pin_i, // Pin 0
  input wire logic ext_irq1_pin_i, // Pin 1
  input wire logic ext_irq0_req_o, // Request 0
  input wire logic ext_irq1_req_o, // Request 1
  input wire logic unit0_overflow_flag_o, // Flag 0
  input wire logic unit1_overflow_flag_o // Flag 1
);
  default clocking dtc_cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Decoded accesses
  wire rd_ctrl = reg_rd_i && (reg_addr_i == `DTC_OFF_CTRL);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == `DTC_OFF_CTRL);
  wire rd_bad = reg_rd_i && (reg_addr_i > `DTC_OFF_U1_HI);
  sequence mode_wr; reg_wr_i && (reg_addr_i == `DTC_OFF_MODE); endsequence
  sequence mode_rd; reg_rd_i && (reg_addr_i == `DTC_OFF_MODE); endsequence
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property (rd_bad |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_readback: assert property (mode_wr ##2 mode_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("mode readback differs");
  chk_ovf0_sticky: assert property ($fell(unit0_overflow_flag_o) |-> $past(wr_ctrl))
    else $error("unit 0 flag cleared by itself");
  chk_ovf1_sticky: assert property ($fell(unit1_overflow_flag_o) |-> $past(wr_ctrl))
    else $error("unit 1 flag cleared by itself");
  chk_ovf0_readback: assert property (rd_ctrl |=> reg_rdata_o[5] == $past(unit0_overflow_flag_o))
    else $error("unit 0 flag pin and bit differ");
  chk_ovf1_readback: assert property (rd_ctrl |=> reg_rdata_o[7] == $past(unit1_overflow_flag_o))
    else $error("unit 1 flag pin and bit differ");
  // Clocks since each interrupt pin was last seen low, saturating
  logic [4:0] low_age0;
  logic [4:0] low_age1;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_age0 <= 5'h1f;
      low_age1 <= 5'h1f;
    end else begin
      if (!ext_irq0_pin_i) begin
        low_age0 <= 5'h00;
      end else if (low_age0 != 5'h1f) begin
        low_age0 <= low_age0 + 5'h01;
      end
      if (!ext_irq1_pin_i) begin
        low_age1 <= 5'h00;
      end else if (low_age1 != 5'h1f) begin
        low_age1 <= low_age1 + 5'h01;
      end
    end
  end
  // A request rises only after a recent low pin or a control write
  chk_irq0_cause: assert property ($rose(ext_irq0_req_o) |-> $past(wr_ctrl) || low_age0 < 5'h10)
    else $error("request 0 without low pin");
  chk_irq1_cause: assert property ($rose(ext_irq1_req_o) |-> $past(wr_ctrl) || low_age1 < 5'h10)
    else $error("request 1 without low pin");
endmodule
bind dtc_timer_unit dtc_timer_props u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .ext_irq0_pin_i(ext_irq0_pin_i), .ext_irq1_pin_i(ext_irq1_pin_i),
  .ext_irq0_req_o(ext_irq0_req_o), .ext_irq1_req_o(ext_irq1_req_o),
  .unit0_overflow_flag_o(unit0_overflow_flag_o), .unit1_overflow_flag_o(unit1_overflow_flag_o)
);
`default_nettype wire

// ### sim/dual_timer_counter_unit_tb_top.sv
// Self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.vh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module dual_timer_counter_unit_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] ack = 2'h0;
  logic [31:0] seed = 32'h33ea_5cbb;
  logic [7:0] v;
  wire [7:0] rdata;
  wire [3:0] pins;
  wire req0, req1, ovf0, ovf1;
  int errors = 0;
  int samples_checked = 0;
  int lo, hi, ov, ov1, m, u, runv, e, scr;
  dtc_pin_model pm (.core_clk_i(core_clk_i), .pins_o(pins));
  dtc_timer_unit uut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .unit0_count_pin_i(pins[`DTC_PIN_CNT0]), .unit1_count_pin_i(pins[`DTC_PIN_CNT1]),
    .ext_irq0_pin_i(pins[`DTC_PIN_IRQ0]), .ext_irq1_pin_i(pins[`DTC_PIN_IRQ1]),
    .ext_irq0_ack_i(ack[0]), .ext_irq1_ack_i(ack[1]), .ext_irq0_req_o(req0),
    .ext_irq1_req_o(req1), .unit0_overflow_flag_o(ovf0), .unit1_overflow_flag_o(ovf1)
  );
  // 10 MHz oscillator
  always #50 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Strobe one cycle, then idle one so strobes never get reassigned in a step
  task automatic wr_reg(input int a, input int d);
    addr <= a[2:0];
    wdata <= d[7:0];
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd_reg(input int a, output logic [7:0] d);
    addr <= a[2:0];
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    // Data stand in the cycle after the strobe; take them at its closing edge
    @(posedge core_clk_i);
    d = rdata;
  endtask
  // Reference model: one machine-cycle step of a count chain
  function automatic void step(input int md, inout int l, inout int h, inout int f);
    int c;
    case (md)
      0: begin
        c = h * 32 + (l & 31) + 1;
        f |= c >> 13;
        h = (c >> 5) & 255;
        l = (l & 224) | (c & 31);
      end
      1: begin
        c = h * 256 + l + 1;
        f |= c >> 16;
        h = (c >> 8) & 255;
        l = c & 255;
      end
      2: begin
        l = l + 1;
        if (l > 255) begin
          f = 1;
          l = h;
        end
      end
      default: begin
        l = l + 1;
        f |= l >> 8;
        l = l & 255;
      end
    endcase
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    repeat (40000) @(posedge core_clk_i);
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    for (int a = 0; a < 7; a++) begin
      rd_reg(a, v);
      `CHK("reset or unmapped", 8'h00, v)
    end
    // Gate pins low: a gated stop then freezes both units
    pm.hold(`DTC_PIN_IRQ0, 1'b0);
    pm.hold(`DTC_PIN_IRQ1, 1'b0);
    for (u = 0; u < 2; u++) begin
      for (m = 0; m < 4; m++) begin
        seed = lfsr(seed);
        lo = 252 | seed[1:0];
        hi = (m == 2) ? seed[15:8] : 255;
        ov = 0;
        ov1 = 0;
        runv = (u == 1) ? 8'h40 : (m == 3) ? 8'h50 : 8'h10;
        wr_reg(`DTC_OFF_CTRL, 0);
        wr_reg(`DTC_OFF_MODE, m << (4 * u));
        rd_reg(`DTC_OFF_MODE, v);
        `CHK("mode", m << (4 * u), v)
        wr_reg(2 + 2 * u, lo);
        wr_reg(3 + 2 * u, hi);
        wr_reg(`DTC_OFF_CTRL, runv);
        // Run edges total exactly six machine cycles
        repeat (70) @(posedge core_clk_i);
        wr_reg(`DTC_OFF_MODE, 8'h88);
        for (int k = 0; k < 6; k++) begin
          if (u == 0 && m == 3) begin
            step(3, lo, scr, ov);
            step(3, hi, scr, ov1);
          end else if (m != 3) step(m, lo, hi, ov);
        end
        e = runv | (ov << (5 + 2 * u)) | (ov1 << 7);
        rd_reg(2 + 2 * u, v);
        `CHK("low byte", (m == 0) ? (lo & 31) : lo, (m == 0) ? (v & 8'h1f) : v)
        rd_reg(3 + 2 * u, v);
        `CHK("high byte", hi, v)
        rd_reg(`DTC_OFF_CTRL, v);
        `CHK("control", e, v)
        `CHK("flag pins", ((e >> 6) & 2) | ((e >> 5) & 1), {ovf1, ovf0})
      end
    end
    `CHK("level requests", 2'b11, {req1, req0})
    pm.hold(`DTC_PIN_IRQ0, 1'b1);
    pm.hold(`DTC_PIN_IRQ1, 1'b1);
    wr_reg(`DTC_OFF_CTRL, 8'h01);
    repeat (24) @(posedge core_clk_i);
    pm.pulse(`DTC_PIN_IRQ0, 1);
    repeat (24) @(posedge core_clk_i);
    `CHK("edge request", 1'b1, req0)
    rd_reg(`DTC_OFF_CTRL, v);
    `CHK("edge flag", 8'h03, v)
    ack <= 2'b11;
    @(posedge core_clk_i);
    ack <= 2'b00;
    repeat (2) @(posedge core_clk_i);
    `CHK("serviced request", 1'b0, req0)
    // Both units count pin edges at the top rate
    wr_reg(`DTC_OFF_CTRL, 0);
    wr_reg(`DTC_OFF_MODE, 8'h55);
    for (int a = 2; a < 6; a++) wr_reg(a, 0);
    wr_reg(`DTC_OFF_CTRL, 8'h50);
    pm.pulse(`DTC_PIN_CNT0, 3);
    pm.pulse(`DTC_PIN_CNT1, 2);
    repeat (48) @(posedge core_clk_i);
    wr_reg(`DTC_OFF_CTRL, 0);
    rd_reg(`DTC_OFF_U0_LO, v);
    `CHK("pin count 0", 8'h03, v)
    rd_reg(`DTC_OFF_U1_LO, v);
    `CHK("pin count 1", 8'h02, v)
    finish_test();
  end
endmodule
`default_nettype wire
